// *** rtl/scu_pkg.sv ***
// constants and types for the system control unit
package scu_pkg;

	// ----------------------------------------------------------------
	// sfr offsets (zero page low byte)
	// ----------------------------------------------------------------
	localparam logic [7:0]  SCU_ADDR_RESET_CONFIRM = 8'hB0;
	localparam logic [7:0]  SCU_ADDR_IRQ_ENABLE_0  = 8'hB2;
	localparam logic [7:0]  SCU_ADDR_IRQ_ENABLE_1  = 8'hB3;
	localparam logic [7:0]  SCU_ADDR_IRQ_PENDING_0 = 8'hB4;
	localparam logic [7:0]  SCU_ADDR_IRQ_PENDING_1 = 8'hB5;
	localparam logic [7:0]  SCU_ADDR_SYSTEM_FLAGS  = 8'hB7;
	localparam logic [7:0]  SCU_ADDR_DIVIDER       = 8'hB9;
	localparam logic [7:0]  SCU_ADDR_CLOCK_SELECT  = 8'hBA;
	localparam logic [7:0]  SCU_ADDR_POWER_CONTROL = 8'hBC;
	localparam logic [7:0]  SCU_ADDR_WRITE_UNLOCK  = 8'hFA;

	// ----------------------------------------------------------------
	// keys, vectors, reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  SCU_UNLOCK_KEY      = 8'h78;
	localparam logic [7:0]  SCU_CONFIRM_KEY     = 8'h90;
	localparam logic [15:0] SCU_VECTOR_ADC      = 16'hFFFC;
	localparam logic [15:0] SCU_VECTOR_SHARED   = 16'hFFFE;
	localparam logic [7:0]  SCU_ENABLE_RST      = 8'h00;
	localparam logic [7:0]  SCU_PENDING_RST     = 8'h00;
	localparam logic [7:0]  SCU_POWER_RST       = 8'h00;
	localparam logic [7:0]  SCU_CLOCK_RST       = 8'h00;
	localparam logic [1:0]  SCU_DIV_RATE_RST    = 2'h0;
	localparam logic [7:0]  SCU_DIVIDER_RST     = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SCU_SYS_WDT_BIT     = 7;
	localparam int SCU_SYS_LVD_BIT     = 0;
	localparam int SCU_PWR_IO_SCOPE    = 6;
	localparam int SCU_PWR_LVD_LEVEL   = 4;
	localparam int SCU_PWR_OSC_HI      = 2;
	localparam int SCU_PWR_OSC_LO      = 1;
	localparam int SCU_PWR_HALT        = 0;
	localparam int SCU_CLK_CPU_SLOW    = 0;
	localparam int SCU_CLK_WAKE_SHORT  = 2;
	localparam int SCU_CLK_MAIN_FULL   = 3;
	localparam int SCU_CLK_DIV_MAIN    = 4;
	localparam int SCU_PEND_ADC_BIT    = 6;
	localparam int SCU_WDT_W           = 7;
	localparam int SCU_RTC_W           = 6;

	// divider event masks for rate codes 0..3 (/4, /32, /64, /128)
	localparam logic [3:0][7:0] SCU_DIV_RATE_MASK = {8'h7F, 8'h3F, 8'h1F, 8'h03};

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SCU_CLK_PERIOD_NS   = 100;
	localparam int SCU_LVR_HOLD_NS     = 1000000;
	localparam int SCU_LVR_HOLD_CYC    =
		(SCU_LVR_HOLD_NS + SCU_CLK_PERIOD_NS - 1) / SCU_CLK_PERIOD_NS;
	localparam int SCU_WAKE_LONG_CYC   = 16384;
	localparam int SCU_WAKE_SHORT_CYC  = 256;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCU_RUN    = 2'b00,
		SCU_STOP   = 2'b01,
		SCU_SETTLE = 2'b10
	} scu_pwr_state_e;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scu_sfr_req_s;

	typedef struct packed {
		logic tm0_underflow;
		logic tm1_underflow;
		logic tm2_underflow;
		logic adc_done;
	} scu_evt_s;

	typedef struct packed {
		logic main_osc_en;
		logic slow_osc_en;
		logic cpu_from_slow;
		logic main_undivided;
	} scu_osc_s;

endpackage : scu_pkg

// *** rtl/scu_system_control.sv ***
// system control unit: interrupts, resets, watchdog, power modes, divider
`timescale 1ns/1ps
//
// Contract
// - pending and enabled source raises request
// - taken irq blocks until cli/enable write
// - adc uses FFFC, others share FFFE
// - enable register bit layout, reset zero
// - port edges and half-second rtc event
// - pending registers read in enable positions
// - writing one clears pending flag
// - watchdog flag set/clear conditions
// - low voltage flag set and clears
// - low voltage reset after 1ms persistence
// - watchdog source /256 then /128
// - firmware restarts watchdog, overflow resets
// - io reset scope excludes watchdog when set
// - two bits choose dual/single/slow/stop
// - stop wakes on port edges or reset
// - slow cpu wake keeps main state
// - halt gates cpu, events resume, protected
// - cpu clock source and main prescale
// - wake debounce 16384 or 256 clocks
// - 8-bit divider taps readable, reset rules
// - divider event rate /4,/32,/64,/128
// - protected writes need 78h unlock once
//
module scu_system_control
	import scu_pkg::*;
#(
	parameter int LVR_HOLD_CYC  = scu_pkg::SCU_LVR_HOLD_CYC,
	parameter int WAKE_LONG_CYC = scu_pkg::SCU_WAKE_LONG_CYC
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	// sfr access from the cpu core
	input  wire scu_pkg::scu_sfr_req_s sfr_req,
	output logic [7:0]                 sfr_rdata_q,
	// cpu interrupt handshake
	input  wire logic                  irq_taken,
	input  wire logic                  clear_irq_disable_instr,
	input  wire logic                  set_irq_disable_instr,
	output logic                       irq_req_q,
	output logic [15:0]                irq_vector_q,
	// on-chip event pulses
	input  wire scu_pkg::scu_evt_s     evt,
	input  wire logic [7:0]            port0_edge_select,
	// pins and analog comparators
	input  wire logic [7:0]            port0_pin,
	input  wire logic [7:0]            port1_pin,
	input  wire logic                  overcurrent_pin,
	input  wire logic                  overvoltage_pin,
	input  wire logic                  external_protect,
	input  wire logic                  ext_reset_pin,
	input  wire logic                  supply_below_lvr,
	input  wire logic                  supply_below_2v4,
	input  wire logic                  supply_below_2v7,
	// oscillator ticks
	input  wire logic                  main_osc_clock,
	input  wire logic                  slow_osc_clock,
	// clock and reset control out
	output scu_pkg::scu_osc_s          osc_q,
	output logic                       cpu_clk_run_q,
	output logic                       system_reset_q,
	output logic                       io_reset_q,
	output logic                       reset_confirmed_q
);
	import scu_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int PIN_W = 25;
	localparam int PIN_OCP = 16;
	localparam int PIN_OVP = 17;
	localparam int PIN_EXTP = 18;
	localparam int PIN_RST = 19;
	localparam int PIN_LVR = 20;
	localparam int PIN_L24 = 21;
	localparam int PIN_L27 = 22;
	localparam logic [PIN_W-1:0] PIN_IDLE = {9'h000, 16'hFFFF};

	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1_q;
	logic [PIN_W-1:0] pin_s2_q;
	logic [PIN_W-1:0] pin_s3_q;
	logic [PIN_W-1:0] pin_q;
	logic [PIN_W-1:0] pin_d;
	logic [PIN_W-1:0] pin_rise;
	logic [PIN_W-1:0] pin_fall;

	assign pin_raw = {2'b00, supply_below_2v7, supply_below_2v4, supply_below_lvr,
		ext_reset_pin, external_protect, overvoltage_pin, overcurrent_pin,
		port1_pin, port0_pin};

	always_comb begin
		// a bit only moves once the second and third stage agree
		pin_d = (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
		pin_rise = pin_d & ~pin_q;
		pin_fall = ~pin_d & pin_q;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_s1_q <= PIN_IDLE;
			pin_s2_q <= PIN_IDLE;
			pin_s3_q <= PIN_IDLE;
			pin_q    <= PIN_IDLE;
		end else if (clk_en) begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q    <= pin_d;
		end
	end

	// ----------------------------------------------------------------
	// register write decode
	// ----------------------------------------------------------------
	logic       wr;
	logic       unlock_q;
	logic [7:0] wd;
	logic       wr_en0;
	logic       wr_en1;
	logic       wr_clr0;
	logic       wr_clr1;
	logic       wr_sys;
	logic       wr_div;
	logic       wr_clk;
	logic       wr_pwr;
	logic       wr_conf;

	assign wr      = clk_en & sfr_req.wr;
	assign wd      = sfr_req.wdata;
	assign wr_en0  = wr & (sfr_req.addr == SCU_ADDR_IRQ_ENABLE_0);
	assign wr_en1  = wr & (sfr_req.addr == SCU_ADDR_IRQ_ENABLE_1);
	assign wr_clr0 = wr & (sfr_req.addr == SCU_ADDR_IRQ_PENDING_0);
	assign wr_clr1 = wr & (sfr_req.addr == SCU_ADDR_IRQ_PENDING_1);
	assign wr_sys  = wr & (sfr_req.addr == SCU_ADDR_SYSTEM_FLAGS);
	assign wr_div  = wr & (sfr_req.addr == SCU_ADDR_DIVIDER);
	assign wr_clk  = wr & (sfr_req.addr == SCU_ADDR_CLOCK_SELECT);
	assign wr_pwr  = wr & (sfr_req.addr == SCU_ADDR_POWER_CONTROL);
	assign wr_conf = wr & (sfr_req.addr == SCU_ADDR_RESET_CONFIRM);

	// ----------------------------------------------------------------
	// reset sources
	// ----------------------------------------------------------------
	logic        wdt_fire;
	logic        lvr_act_q;
	logic [31:0] lvr_cnt_q;
	logic        hard_rst;
	logic        soft_rst;

	// external reset and low voltage reset act as levels
	assign hard_rst = lvr_act_q | pin_q[PIN_RST];
	assign soft_rst = hard_rst | wdt_fire;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lvr_cnt_q <= '0;
			lvr_act_q <= 1'b0;
		end else if (clk_en) begin
			if (!pin_q[PIN_LVR]) begin
				lvr_cnt_q <= '0;
				lvr_act_q <= 1'b0;
			end else if (lvr_cnt_q >= 32'(LVR_HOLD_CYC)) begin
				lvr_act_q <= 1'b1;
			end else begin
				lvr_cnt_q <= lvr_cnt_q + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			unlock_q <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst) begin
				unlock_q <= 1'b0;
			end else if (wr) begin
				// any write other than a repeated key write ends the unlock
				unlock_q <= (sfr_req.addr == SCU_ADDR_WRITE_UNLOCK) &&
					(wd == SCU_UNLOCK_KEY);
			end
		end
	end

	// ----------------------------------------------------------------
	// clock selection and divider chain
	// ----------------------------------------------------------------
	logic [7:0]           clk_sel_q;
	logic [1:0]           div_rate_q;
	logic [7:0]           div_q;
	logic [SCU_WDT_W-1:0] wdt_q;
	logic [SCU_RTC_W-1:0] rtc_q;
	logic                 div_tick;
	logic                 div_carry;
	logic                 div_evt;
	logic                 rtc_evt;
	logic [7:0]           rate_mask;

	always_comb begin
		div_tick = clk_sel_q[SCU_CLK_DIV_MAIN] ? (main_osc_clock & osc_q.main_osc_en)
			: (slow_osc_clock & osc_q.slow_osc_en);
		div_carry = div_tick & (div_q == 8'hFF);
		rate_mask = SCU_DIV_RATE_MASK[div_rate_q];
		div_evt = div_tick & ((div_q & rate_mask) == rate_mask);
		// 64 divider carries give half a second at the nominal slow clock
		rtc_evt = div_carry & (&rtc_q);
		wdt_fire = div_carry & (&wdt_q);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			clk_sel_q  <= SCU_CLOCK_RST;
			div_rate_q <= SCU_DIV_RATE_RST;
		end else if (clk_en) begin
			if (soft_rst) begin
				clk_sel_q  <= SCU_CLOCK_RST;
				div_rate_q <= SCU_DIV_RATE_RST;
			end else begin
				if (wr_clk && unlock_q) begin
					clk_sel_q <= wd;
				end
				if (wr_div) begin
					div_rate_q <= wd[1:0];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			div_q <= SCU_DIVIDER_RST;
			rtc_q <= '0;
		end else if (clk_en) begin
			if (lvr_act_q) begin
				div_q <= SCU_DIVIDER_RST;
				rtc_q <= '0;
			end else if (div_tick) begin
				div_q <= div_q + 8'h01;
				if (div_carry) begin
					rtc_q <= rtc_q + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wdt_q <= '0;
		end else if (clk_en) begin
			if (soft_rst || (wr_sys && unlock_q && wd[SCU_SYS_WDT_BIT])) begin
				wdt_q <= '0;
			end else if (div_carry) begin
				wdt_q <= wdt_q + 7'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt sources, pending and enable
	// ----------------------------------------------------------------
	logic [7:0] en0_q;
	logic [7:0] en1_q;
	logic [7:0] pend0_q;
	logic [4:0] pend1_q;
	logic [7:0] set0;
	logic [4:0] set1;
	logic       block_q;
	logic       p0_evt;
	logic       p1_evt;

	always_comb begin
		p0_evt = |((pin_rise[7:0] & ~port0_edge_select) |
			(pin_fall[7:0] & port0_edge_select));
		p1_evt = |pin_fall[15:8];
		set0 = {rtc_evt, evt.adc_done, div_evt, evt.tm2_underflow,
			evt.tm1_underflow, evt.tm0_underflow, p1_evt, p0_evt};
		set1 = {pin_rise[PIN_EXTP], pin_rise[PIN_OCP], pin_fall[PIN_OCP],
			pin_rise[PIN_OVP], pin_fall[PIN_OVP]};
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en0_q <= SCU_ENABLE_RST;
			en1_q <= SCU_ENABLE_RST;
		end else if (clk_en) begin
			if (soft_rst) begin
				en0_q <= SCU_ENABLE_RST;
				en1_q <= SCU_ENABLE_RST;
			end else begin
				if (wr_en0) begin
					en0_q <= wd;
				end
				if (wr_en1) begin
					en1_q <= {3'b000, wd[4:0]};
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pend0_q <= SCU_PENDING_RST;
			pend1_q <= SCU_PENDING_RST[4:0];
		end else if (clk_en) begin
			if (soft_rst) begin
				pend0_q <= SCU_PENDING_RST;
				pend1_q <= SCU_PENDING_RST[4:0];
			end else begin
				// a zero bit keeps its flag; a fresh event beats the clear
				pend0_q <= (pend0_q & ~({8{wr_clr0}} & wd)) | set0;
				pend1_q <= (pend1_q & ~({5{wr_clr1}} & wd[4:0])) | set1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			block_q <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst) begin
				block_q <= 1'b0;
			end else if (irq_taken || set_irq_disable_instr) begin
				block_q <= 1'b1;
			end else if (clear_irq_disable_instr || wr_en0 || wr_en1) begin
				block_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_req_q    <= 1'b0;
			irq_vector_q <= SCU_VECTOR_SHARED;
		end else if (clk_en) begin
			irq_req_q <= ~soft_rst & ~block_q & ~irq_taken &
				(|(pend0_q & en0_q) | |(pend1_q & en1_q[4:0]));
			// adc has its own vector and is preferred when both pend
			irq_vector_q <= (pend0_q[SCU_PEND_ADC_BIT] & en0_q[SCU_PEND_ADC_BIT]) ?
				SCU_VECTOR_ADC : SCU_VECTOR_SHARED;
		end
	end

	// ----------------------------------------------------------------
	// system flags
	// ----------------------------------------------------------------
	logic wdt_flag_q;
	logic lvd_flag_q;
	logic lvd_cond;
	logic [7:0] pwr_q;

	assign lvd_cond = pwr_q[SCU_PWR_LVD_LEVEL] ? pin_q[PIN_L27] : pin_q[PIN_L24];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wdt_flag_q <= 1'b0;
		end else if (clk_en) begin
			if (wdt_fire) begin
				wdt_flag_q <= 1'b1;
			end else if (hard_rst || (wr_sys && unlock_q && wd[SCU_SYS_WDT_BIT])) begin
				wdt_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lvd_flag_q <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst) begin
				lvd_flag_q <= 1'b0;
			end else if (lvd_cond) begin
				lvd_flag_q <= 1'b1;
			end else if (wr_sys && wd[SCU_SYS_LVD_BIT]) begin
				lvd_flag_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// power control and stop/halt sequencing
	// ----------------------------------------------------------------
	scu_pwr_state_e state_q;
	logic [14:0]    settle_q;
	logic           saved_main_q;
	logic           saved_slow_q;
	logic           stop_wake;

	// oscillators are off in stop, so only port0 edges and port1 falling edges can wake it
	assign stop_wake = p0_evt | (|pin_rise[7:0]) | (|pin_fall[7:0]) | p1_evt;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pwr_q        <= SCU_POWER_RST;
			state_q      <= SCU_RUN;
			settle_q     <= '0;
			saved_main_q <= 1'b1;
			saved_slow_q <= 1'b1;
		end else if (clk_en) begin
			if (soft_rst) begin
				pwr_q   <= SCU_POWER_RST;
				state_q <= SCU_RUN;
			end else begin
				unique case (state_q)
					SCU_RUN: begin
						if (wr_pwr) begin
							pwr_q[SCU_PWR_IO_SCOPE]  <= wd[SCU_PWR_IO_SCOPE];
							pwr_q[SCU_PWR_LVD_LEVEL] <= wd[SCU_PWR_LVD_LEVEL];
							if (unlock_q) begin
								pwr_q[2:0] <= wd[2:0];
							end
						end else if (|{set0, set1}) begin
							pwr_q[SCU_PWR_HALT] <= 1'b0;
						end
						if (pwr_q[2:1] == 2'b11) begin
							saved_main_q <= osc_q.main_osc_en;
							saved_slow_q <= osc_q.slow_osc_en;
							state_q      <= SCU_STOP;
						end
					end
					SCU_STOP: begin
						if (stop_wake) begin
							if (clk_sel_q[SCU_CLK_CPU_SLOW]) begin
								pwr_q[2:1] <= {~saved_main_q, 1'b0};
							end else begin
								pwr_q[2:1] <= {1'b0, ~saved_slow_q};
							end
							settle_q <= clk_sel_q[SCU_CLK_WAKE_SHORT] ?
								15'(SCU_WAKE_SHORT_CYC - 1) : 15'(WAKE_LONG_CYC - 1);
							state_q <= SCU_SETTLE;
						end
					end
					SCU_SETTLE: begin
						if (settle_q == 15'h0000) begin
							state_q <= SCU_RUN;
						end else begin
							settle_q <= settle_q - 15'h0001;
						end
					end
					default: begin
						state_q <= SCU_RUN;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// registered control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			osc_q         <= '{main_osc_en: 1'b1, slow_osc_en: 1'b1,
				cpu_from_slow: 1'b0, main_undivided: 1'b0};
			cpu_clk_run_q <= 1'b1;
		end else if (clk_en) begin
			osc_q.main_osc_en    <= ~pwr_q[SCU_PWR_OSC_HI];
			osc_q.slow_osc_en    <= ~pwr_q[SCU_PWR_OSC_LO];
			osc_q.cpu_from_slow  <= clk_sel_q[SCU_CLK_CPU_SLOW];
			osc_q.main_undivided <= clk_sel_q[SCU_CLK_MAIN_FULL];
			cpu_clk_run_q <= (state_q == SCU_RUN) & ~pwr_q[SCU_PWR_HALT] &
				(pwr_q[2:1] != 2'b11);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			system_reset_q <= 1'b1;
			io_reset_q     <= 1'b1;
		end else if (clk_en) begin
			system_reset_q <= soft_rst;
			io_reset_q     <= hard_rst | (wdt_fire & ~pwr_q[SCU_PWR_IO_SCOPE]);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reset_confirmed_q <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst) begin
				reset_confirmed_q <= 1'b0;
			end else if (wr_conf) begin
				reset_confirmed_q <= (wd[7:4] == SCU_CONFIRM_KEY[7:4]);
			end
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sfr_rdata_q <= 8'h00;
		end else if (clk_en && sfr_req.rd) begin
			unique case (sfr_req.addr)
				SCU_ADDR_IRQ_PENDING_0: sfr_rdata_q <= pend0_q;
				SCU_ADDR_IRQ_PENDING_1: sfr_rdata_q <= {3'b000, pend1_q};
				SCU_ADDR_SYSTEM_FLAGS:  sfr_rdata_q <= {wdt_flag_q, 6'h00, lvd_flag_q};
				SCU_ADDR_DIVIDER:       sfr_rdata_q <= div_q;
				default:                sfr_rdata_q <= 8'h00;
			endcase
		end
	end

endmodule : scu_system_control

// *** tb/scu_cpu_model.sv ***
// cpu core stand-in that accepts one interrupt when told to
`timescale 1ns/1ps
module scu_cpu_model (
	// clock and request
	input  wire logic clk_sys,
	input  wire logic irq_req_q,
	input  wire logic accept,
	// acknowledge
	output logic      irq_taken
);
	logic done_q;
	initial irq_taken = 1'b0;
	initial done_q = 1'b0;
	// one-shot so a slow-falling request is not taken twice
	always @(posedge clk_sys) begin
		irq_taken <= accept && irq_req_q && !done_q;
		done_q <= accept && (done_q || irq_req_q);
	end
endmodule : scu_cpu_model

// *** tb/scu_system_control_sva.sv ***
// port assertions for the system control unit
`timescale 1ns/1ps
module scu_system_control_sva
	import scu_pkg::*;
(
	// clock, reset, bus
	input wire logic                  clk_sys, sys_rst, clk_en,
	input wire scu_pkg::scu_sfr_req_s sfr_req,
	input wire logic [7:0]            sfr_rdata_q,
	// irq and control outputs
	input wire logic                  irq_taken, irq_req_q, cpu_clk_run_q, reset_confirmed_q,
	input wire logic [15:0]           irq_vector_q,
	input wire scu_pkg::scu_osc_s     osc_q
);
	logic wr_ok, unl, pwr_wr;
	assign wr_ok = clk_en && sfr_req.wr;
	assign unl = wr_ok && sfr_req.addr == SCU_ADDR_WRITE_UNLOCK && sfr_req.wdata == SCU_UNLOCK_KEY;
	assign pwr_wr = wr_ok && sfr_req.addr == SCU_ADDR_POWER_CONTROL;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_vector; irq_vector_q == SCU_VECTOR_ADC || irq_vector_q == SCU_VECTOR_SHARED; endproperty
	a_vector: assert property (p_vector) else $error("vector outside both slots");
	property p_reset;
		disable iff (1'b0) sys_rst |=> !irq_req_q && !reset_confirmed_q && cpu_clk_run_q;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_block; clk_en && irq_taken |-> ##[1:2] !irq_req_q; endproperty
	a_block: assert property (p_block) else $error("request not blocked");
	sequence s_unl_pwr; unl ##1 !wr_ok ##1 pwr_wr; endsequence
	property p_halt; s_unl_pwr ##0 sfr_req.wdata == 8'h01 |-> ##[1:2] !cpu_clk_run_q; endproperty
	a_halt: assert property (p_halt) else $error("halt not taken");
	property p_locked;
		(wr_ok && !unl) ##1 !wr_ok ##1 (pwr_wr && sfr_req.wdata == 8'h01 && cpu_clk_run_q)
			|=> cpu_clk_run_q [*2];
	endproperty
	a_locked: assert property (p_locked) else $error("locked write took effect");
	property p_unmapped; clk_en && sfr_req.rd && sfr_req.addr == 8'hB1 |=> sfr_rdata_q == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_confirm;
		wr_ok && sfr_req.addr == SCU_ADDR_RESET_CONFIRM && sfr_req.wdata == SCU_CONFIRM_KEY
			|-> ##[1:2] reset_confirmed_q;
	endproperty
	a_confirm: assert property (p_confirm) else $error("confirm not seen");
	property p_stop; s_unl_pwr ##0 sfr_req.wdata[2:1] == 2'b11
		|-> ##[1:3] !osc_q.main_osc_en && !osc_q.slow_osc_en; endproperty
	a_stop: assert property (p_stop) else $error("stop left an oscillator on");
	property p_single; s_unl_pwr ##0 sfr_req.wdata[2:1] == 2'b01
		|-> ##[1:3] osc_q.main_osc_en && !osc_q.slow_osc_en; endproperty
	a_single: assert property (p_single) else $error("single mode wrong");
	c_adc: cover property (irq_req_q && irq_vector_q == SCU_VECTOR_ADC);
	c_halt: cover property (!cpu_clk_run_q);
	c_stop: cover property (!osc_q.main_osc_en);
endmodule : scu_system_control_sva
bind scu_system_control scu_system_control_sva u_sva (.*);

// *** tb/scu_system_control_tb_top.sv ***
// self-checking bench for the system control unit
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module scu_system_control_tb_top;
	import scu_pkg::*;
	logic clk_sys = 0, sys_rst = 1, clk_en = 1, accept = 0, irq_taken, irq_req_q;
	logic clear_irq_disable_instr = 0, set_irq_disable_instr = 0, external_protect = 0;
	logic ext_reset_pin = 0, supply_below_lvr = 0, supply_below_2v4 = 0, supply_below_2v7 = 0;
	logic overcurrent_pin = 0, overvoltage_pin = 0, main_osc_clock = 0, slow_osc_clock = 0;
	logic cpu_clk_run_q, system_reset_q, io_reset_q, reset_confirmed_q;
	logic [7:0] port0_pin = 8'hFF, port1_pin = 8'hFF, port0_edge_select = 8'h00;
	logic [7:0] sfr_rdata_q, ev;
	logic [15:0] irq_vector_q;
	scu_sfr_req_s sfr_req = '0;
	scu_evt_s evt = '0;
	scu_osc_s osc_q;
	int n_errors = 0, n_compared = 0, i;
	scu_system_control #(.LVR_HOLD_CYC(8), .WAKE_LONG_CYC(16)) uut (.*);
	scu_cpu_model u_cpu (.*);
	initial forever #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		main_osc_clock <= 1'b1;
		// divider held still so its events stay out of the pending reads
		slow_osc_clock <= 1'b0;
	end
	task tick(input int n); repeat (n) @(posedge clk_sys); endtask : tick
	task settle(input int n); tick(n); @(negedge clk_sys); endtask : settle
	task wr(input logic [7:0] a, d);
		@(posedge clk_sys) sfr_req <= '{1'b0, 1'b1, a, d};
		@(posedge clk_sys) sfr_req <= '0;
	endtask : wr
	task unl_wr(input logic [7:0] a, d); wr(SCU_ADDR_WRITE_UNLOCK, SCU_UNLOCK_KEY); wr(a, d);
	endtask : unl_wr
	task rd(input logic [7:0] a, e);
		@(posedge clk_sys) sfr_req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk_sys) sfr_req <= '0;
		@(negedge clk_sys) `CHK(sfr_rdata_q, e)
	endtask : rd
	task pulse(input scu_evt_s e, input logic c, s);
		@(posedge clk_sys) begin evt <= e; clear_irq_disable_instr <= c; set_irq_disable_instr <= s; end
		@(posedge clk_sys) begin evt <= '0; clear_irq_disable_instr <= 0; set_irq_disable_instr <= 0; end
	endtask : pulse
	task test_done;
		if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial begin
		tick(8);
		sys_rst <= 1'b0;
		settle(1);
		`CHK(irq_vector_q, SCU_VECTOR_SHARED)
		rd(SCU_ADDR_IRQ_PENDING_0, 8'h00);
		rd(8'hB1, 8'h00);
		wr(SCU_ADDR_IRQ_ENABLE_0, 8'h5C);
		for (i = 0; i < 4; i++) begin
			ev = (i == 3) ? 8'h40 : (8'h04 << i);
			pulse(scu_evt_s'(4'h8 >> i), 0, 0);
			settle(1);
			`CHK(irq_req_q, 1'b1)
			`CHK(irq_vector_q, i == 3 ? SCU_VECTOR_ADC : SCU_VECTOR_SHARED)
			wr(SCU_ADDR_IRQ_PENDING_0, 8'h00);
			rd(SCU_ADDR_IRQ_PENDING_0, ev);
			wr(SCU_ADDR_IRQ_PENDING_0, ev);
			settle(1);
			`CHK(irq_req_q, 1'b0)
		end
		accept <= 1'b1;
		pulse(scu_evt_s'(4'h8), 0, 0);
		settle(5);
		`CHK(irq_req_q, 1'b0)
		@(posedge clk_sys) accept <= 1'b0;
		pulse('0, 1, 0);
		settle(1);
		`CHK(irq_req_q, 1'b1)
		pulse('0, 0, 1);
		settle(1);
		`CHK(irq_req_q, 1'b0)
		wr(SCU_ADDR_IRQ_ENABLE_0, 8'h5C);
		settle(1);
		`CHK(irq_req_q, 1'b1)
		wr(SCU_ADDR_IRQ_PENDING_0, 8'hFF);
		@(posedge clk_sys) port1_pin <= 8'hFE;
		@(posedge clk_sys) port0_pin <= 8'hFE;
		settle(8);
		rd(SCU_ADDR_IRQ_PENDING_0, 8'h02);
		@(posedge clk_sys) port0_pin <= 8'hFF;
		settle(8);
		rd(SCU_ADDR_IRQ_PENDING_0, 8'h03);
		@(posedge clk_sys) overvoltage_pin <= 1'b1;
		settle(8);
		rd(SCU_ADDR_IRQ_PENDING_1, 8'h02);
		@(posedge clk_sys) begin overvoltage_pin <= 1'b0; overcurrent_pin <= 1'b1; port1_pin <= 8'hFF; end
		settle(8);
		rd(SCU_ADDR_IRQ_PENDING_1, 8'h0B);
		wr(SCU_ADDR_IRQ_PENDING_1, 8'hFF);
		wr(SCU_ADDR_IRQ_PENDING_0, 8'hFF);
		@(posedge clk_sys) supply_below_2v4 <= 1'b1;
		settle(8);
		rd(SCU_ADDR_SYSTEM_FLAGS, 8'h01);
		@(posedge clk_sys) supply_below_2v4 <= 1'b0;
		settle(8);
		wr(SCU_ADDR_SYSTEM_FLAGS, 8'h01);
		rd(SCU_ADDR_SYSTEM_FLAGS, 8'h00);
		wr(SCU_ADDR_SYSTEM_FLAGS, 8'h00);
		wr(SCU_ADDR_POWER_CONTROL, 8'h01);
		settle(2);
		`CHK(cpu_clk_run_q, 1'b1)
		unl_wr(SCU_ADDR_POWER_CONTROL, 8'h01);
		settle(1);
		`CHK(cpu_clk_run_q, 1'b0)
		pulse(scu_evt_s'(4'h8), 0, 0);
		settle(3);
		`CHK(cpu_clk_run_q, 1'b1)
		wr(SCU_ADDR_RESET_CONFIRM, SCU_CONFIRM_KEY);
		settle(1);
		`CHK(reset_confirmed_q, 1'b1)
		unl_wr(SCU_ADDR_POWER_CONTROL, 8'h06);
		settle(3);
		`CHK(osc_q.slow_osc_en, 1'b0)
		@(posedge clk_sys) port1_pin <= 8'hFE;
		for (i = 0; i < 80 && osc_q.main_osc_en !== 1'b1; i++) @(negedge clk_sys);
		`CHK(osc_q.main_osc_en, 1'b1)
		@(posedge clk_sys) port1_pin <= 8'hFF;
		// power writes are ignored until the wake debounce has run out
		settle(20);
		unl_wr(SCU_ADDR_POWER_CONTROL, 8'h02);
		settle(3);
		`CHK(osc_q.main_osc_en, 1'b1)
		`CHK(osc_q.slow_osc_en, 1'b0)
		@(posedge clk_sys) supply_below_lvr <= 1'b1;
		@(posedge clk_sys) supply_below_lvr <= 1'b0;
		settle(12);
		`CHK(system_reset_q, 1'b0)
		@(posedge clk_sys) supply_below_lvr <= 1'b1;
		for (i = 0; i < 40 && system_reset_q !== 1'b1; i++) @(negedge clk_sys);
		`CHK(system_reset_q, 1'b1)
		test_done();
	end
endmodule : scu_system_control_tb_top
